// ==== hw/dmcc_pkg.sv ====
// package for the dma channel control core: offsets, fields, enums
// assumes a plain register port with word addresses and 32-bit data
package dmcc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] DMCC_OFS_DEST  = 4'h0;
  localparam logic [3:0] DMCC_OFS_COUNT = 4'h1;
  localparam logic [3:0] DMCC_OFS_MODE  = 4'h2;
  localparam logic [3:0] DMCC_OFS_SRC   = 4'h3;

  // ****************************************************************
  // mode register fields
  // ****************************************************************
  localparam int DMCC_B_RUN    = 15;
  localparam int DMCC_B_BEF    = 14;
  localparam int DMCC_B_RAKE   = 13;
  localparam int DMCC_B_ENDE   = 12;
  localparam int DMCC_B_EDGE   = 11;
  localparam int DMCC_B_AMS    = 10;
  localparam int DMCC_B_MDHI   = 9;
  localparam int DMCC_B_MDLO   = 8;
  localparam int DMCC_B_IRQEN  = 7;
  localparam int DMCC_B_IRF    = 6;
  localparam int DMCC_B_COUNT_END_IRQ_EN  = 5;
  localparam int DMCC_B_DIR    = 4;
  localparam int DMCC_B_SZLO   = 3;
  localparam int DMCC_B_RSV2   = 2;
  localparam int DMCC_B_SZLONG = 1;
  localparam int DMCC_B_RSV0   = 0;
  localparam logic [15:0] DMCC_MODE_RST = 16'h0000;
  localparam logic [31:0] DMCC_TOP_MASK = 32'h00FF_FFFF;
  localparam logic [8:0]  DMCC_BLK_MAX  = 9'h100;

  // ****************************************************************
  // transfer modes and unit sizes
  // ****************************************************************
  typedef enum logic [1:0] {
    DMCC_AUTO_STEAL = 2'h0,
    DMCC_AUTO_BURST = 2'h1,
    DMCC_EXT_STEAL  = 2'h2,
    DMCC_EXT_BLOCK  = 2'h3
  } dmcc_mode_e;

  typedef enum logic [1:0] {
    DMCC_SZ_BYTE = 2'h0,
    DMCC_SZ_WORD = 2'h1,
    DMCC_SZ_LONG = 2'h2,
    DMCC_SZ_RSVD = 2'h3
  } dmcc_size_e;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dmcc_req_s;

  // external event inputs
  typedef struct packed {
    logic nmi;
    logic abort;
    logic src_rpt_ovf;
    logic dst_rpt_ovf;
  } dmcc_evt_s;

endpackage

// ==== hw/dmcc_core.sv ====
// dma channel control core: destination address, transfer count and
// mode register, transfer sequencing and request/ack/end pins.
// assumes one clock, synchronous inputs, a bus that grants each
// requested unit as a one-cycle xfer_done pulse from the fabric.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps

module dmcc_core
  import dmcc_pkg::*;
#(
  parameter int ADDR_W = 32
)
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire dmcc_pkg::dmcc_req_s reg_req,
  output logic [31:0]            reg_rdata,
  input  wire dmcc_pkg::dmcc_evt_s evt,
  input  wire logic              xfer_req_n,
  input  wire logic              xfer_done,
  output logic                   bus_req,
  output logic [31:0]            dest_addr,
  output logic                   dest_is_device,
  output logic [1:0]             unit_size,
  output logic                   xfer_ack_n,
  output logic                   req_accept_n,
  output logic                   req_accept_oe,
  output logic                   xfer_done_n,
  output logic                   xfer_done_oe,
  output logic                   irq
);
  import dmcc_pkg::*;

  initial
  begin
    if (ADDR_W != 32)
      $error("dmcc_core: only 32-bit addresses supported");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [23:0] dest_q;
  logic [23:0] count_q;
  logic [15:0] mode_q;
  logic [8:0]  blk_left_q;
  logic        req_prev_q;
  logic        armed_q;
  logic        first_q;
  logic        stop_req_q;
  logic        bef_seen_q;
  logic        irf_seen_q;
  logic        active_q;
  logic        pending_q;
  logic        done_q;

  logic        run;
  logic        is_block;
  logic        is_auto;
  logic        req_hit;
  logic        unit_done;
  logic        block_end;
  logic        count_end;
  logic        halt_evt;
  logic        wr_dest;
  logic        wr_count;
  logic        wr_mode;
  logic [8:0]  blk_size;
  logic [2:0]  step;

  // step in bytes for the chosen unit
  function automatic logic [2:0] unit_step(input logic lng, input logic lo);
    if (lng && !lo)
      return 3'h4;
    else if (lo)
      return 3'h2;
    else
      return 3'h1;
  endfunction

  assign run      = mode_q[DMCC_B_RUN];
  assign is_block = (mode_q[9:8] == DMCC_EXT_BLOCK);
  assign is_auto  = !mode_q[DMCC_B_MDHI];
  assign step     = unit_step(mode_q[DMCC_B_SZLONG], mode_q[DMCC_B_SZLO]);
  assign blk_size = (count_q[23:16] == 8'h00) ? DMCC_BLK_MAX
                    : {1'b0, count_q[23:16]};
  assign wr_dest  = reg_req.wr && reg_req.addr == DMCC_OFS_DEST;
  assign wr_count = reg_req.wr && reg_req.addr == DMCC_OFS_COUNT;
  assign wr_mode  = reg_req.wr && reg_req.addr == DMCC_OFS_MODE;

  // ****************************************************************
  // request sensing
  // ****************************************************************
  // edge mode still uses level for the first unit after enabling
  assign req_hit = (!mode_q[DMCC_B_EDGE] || first_q) ? !xfer_req_n
                   : (req_prev_q && !xfer_req_n);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      req_prev_q <= 1'b1;
    else
      req_prev_q <= xfer_req_n;
  end

  // armed only by a request seen after the run bit rose
  always_ff @(posedge mclk)
  begin
    if (!resetn || !run)
      armed_q <= 1'b0;
    else if (!active_q && !is_auto && req_hit)
      armed_q <= 1'b1;
    else if (active_q)
      armed_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn || !run)
      first_q <= 1'b1;
    else if (unit_done)
      first_q <= 1'b0;
  end

  // ****************************************************************
  // transfer sequencing
  // ****************************************************************
  assign unit_done = active_q && xfer_done;
  assign block_end = unit_done && (!is_block || blk_left_q == 9'h001);
  assign count_end = block_end && (is_block ? count_q[15:0] == 16'h0001
                                            : count_q == 24'h00_0001);
  assign halt_evt  = evt.abort
                     || (active_q && (evt.src_rpt_ovf || evt.dst_rpt_ovf));

  // one unit in flight; burst keeps it asserted, steal drops per unit
  always_ff @(posedge mclk)
  begin
    if (!resetn || evt.nmi || halt_evt)
      active_q <= 1'b0;
    else if (!active_q && run && !stop_req_q && (is_auto || armed_q))
      active_q <= 1'b1;
    else if (count_end || (block_end && (stop_req_q || !is_block)
                           && mode_q[9:8] != DMCC_AUTO_BURST))
      active_q <= 1'b0;
    else if (block_end && !run)
      active_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn || !active_q)
      blk_left_q <= blk_size;
    else if (unit_done)
      blk_left_q <= (blk_left_q == 9'h001) ? blk_size
                    : 9'(blk_left_q - 9'h001);
  end

  // block mode: software stop deferred to block end
  always_ff @(posedge mclk)
  begin
    if (!resetn || !run)
      stop_req_q <= 1'b0;
    else if (wr_mode && !reg_req.wdata[DMCC_B_RUN] && is_block && active_q)
      stop_req_q <= 1'b1;
    else if (block_end)
      stop_req_q <= 1'b0;
  end

  // ****************************************************************
  // destination and count
  // ****************************************************************
  // software must not write these mid-transfer; write wins only idle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dest_q <= 24'h00_0000;
    else if (wr_dest && !active_q)
      dest_q <= reg_req.wdata[23:0];
    else if (unit_done)
      dest_q <= 24'(dest_q + {21'h00_0000, step});
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      count_q <= 24'h00_0000;
    else if (wr_count && !active_q)
      count_q <= reg_req.wdata[23:0];
    else if (!is_block && unit_done && count_q != 24'h00_0000)
      count_q <= 24'(count_q - 24'h00_0001);
    else if (is_block && block_end && count_q[15:0] != 16'h0000)
      count_q[15:0] <= 16'(count_q[15:0] - 16'h0001);
  end

  // ****************************************************************
  // mode register
  // ****************************************************************
  // flags clear only after being read as one, IRF also on a write setting run; set beats clear
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      bef_seen_q <= 1'b0;
      irf_seen_q <= 1'b0;
    end
    else if (reg_req.rd && reg_req.addr == DMCC_OFS_MODE)
    begin
      bef_seen_q <= mode_q[DMCC_B_BEF];
      irf_seen_q <= mode_q[DMCC_B_IRF];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mode_q <= DMCC_MODE_RST;
    else
    begin
      if (wr_mode)
      begin
        if (!run)
          mode_q[13:0] <= {reg_req.wdata[13:7], mode_q[DMCC_B_IRF],
                           reg_req.wdata[5:0]};
        else
          mode_q[DMCC_B_IRQEN] <= reg_req.wdata[DMCC_B_IRQEN];
        if (reg_req.wdata[DMCC_B_RUN])
        begin
          mode_q[DMCC_B_RUN] <= 1'b1;
          mode_q[DMCC_B_IRF] <= 1'b0;
        end
        else if (!(is_block && active_q))
          mode_q[DMCC_B_RUN] <= 1'b0;
        if (!reg_req.wdata[DMCC_B_IRF] && irf_seen_q)
          mode_q[DMCC_B_IRF] <= 1'b0;
        if (!reg_req.wdata[DMCC_B_BEF] && bef_seen_q)
          mode_q[DMCC_B_BEF] <= 1'b0;
      end
      if (stop_req_q && block_end)
        mode_q[DMCC_B_RUN] <= 1'b0;
      if (count_end || halt_evt || evt.nmi)
        mode_q[DMCC_B_RUN] <= 1'b0;
      if (evt.nmi && active_q && is_block)
        mode_q[DMCC_B_BEF] <= 1'b1;
      if ((count_end && mode_q[DMCC_B_COUNT_END_IRQ_EN])
          || (active_q && (evt.src_rpt_ovf || evt.dst_rpt_ovf)))
        mode_q[DMCC_B_IRF] <= 1'b1;
    end
  end

  // ****************************************************************
  // pins and read back
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      pending_q <= 1'b0;
    else
      pending_q <= armed_q && !active_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else
      done_q <= count_end;
  end

  assign bus_req        = active_q;
  assign dest_addr      = {8'h00, dest_q};
  assign dest_is_device = mode_q[DMCC_B_AMS]
                          && mode_q[DMCC_B_DIR] == 1'b0;
  assign unit_size      = {mode_q[DMCC_B_SZLONG], mode_q[DMCC_B_SZLO]};
  assign xfer_ack_n     = !(mode_q[DMCC_B_AMS] && active_q);
  assign req_accept_n   = !pending_q;
  assign req_accept_oe  = mode_q[DMCC_B_RAKE];
  assign xfer_done_n    = !done_q;
  assign xfer_done_oe   = mode_q[DMCC_B_ENDE];
  assign irq            = mode_q[DMCC_B_IRF] && mode_q[DMCC_B_IRQEN];

  // one-cycle read latency; unmapped words read zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_req.rd)
      unique case (reg_req.addr)
        DMCC_OFS_DEST:  reg_rdata <= {8'h00, dest_q};
        DMCC_OFS_COUNT: reg_rdata <= {8'h00, count_q};
        DMCC_OFS_MODE:  reg_rdata <= {16'h0000, mode_q};
        default:        reg_rdata <= 32'h0000_0000;
      endcase
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

// ==== testbench/dmcc_core_props.sv ====
// port checker for the dma channel control core
// assumes the core's port names and the package's register offsets
`timescale 1ns/1ps

module dmcc_core_props
(
  input wire logic                mclk,
  input wire logic                resetn,
  input wire dmcc_pkg::dmcc_req_s reg_req,
  input wire logic [31:0]         reg_rdata,
  input wire dmcc_pkg::dmcc_evt_s evt,
  input wire logic                bus_req,
  input wire logic [31:0]         dest_addr,
  input wire logic                dest_is_device,
  input wire logic                req_accept_oe,
  input wire logic                xfer_done_n,
  input wire logic                xfer_done_oe,
  input wire logic                irq
);
  import dmcc_pkg::*;
  // ********
  // helpers: one clock, so one default
  // ********
  logic wr_mode;
  assign wr_mode = reg_req.wr && reg_req.addr == DMCC_OFS_MODE;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_TOP_ZERO: assert property
    (dest_addr[31:24] == 8'h00) else $error("dest top byte set");
  AST_RD_ONE: assert property
    (reg_rdata != 32'h0000_0000 |-> $past(reg_req.rd))
    else $error("read data outside read slot");
  AST_RAKE_OE: assert property
    ($rose(req_accept_oe) |-> $past(wr_mode && reg_req.wdata[13]))
    else $error("accept pin enabled unasked");
  AST_ENDE_OE: assert property
    ($rose(xfer_done_oe) |-> $past(wr_mode && reg_req.wdata[12]))
    else $error("end pin enabled unasked");
  AST_DEV_DEST: assert property
    ($rose(dest_is_device) |->
      $past(wr_mode && reg_req.wdata[10] && !reg_req.wdata[4]))
    else $error("device target without single mode write");
  AST_DONE_PULSE: assert property
    ($fell(xfer_done_n) |-> !bus_req ##1 xfer_done_n)
    else $error("end pulse wrong");
  AST_IRQ_CAUSE: assert property
    ($rose(irq) |-> !xfer_done_n || $past(reg_req.wr)
      || $past(evt.src_rpt_ovf || evt.dst_rpt_ovf))
    else $error("irq without cause");
  AST_NMI_STOP: assert property
    (evt.nmi || evt.abort |-> ##2 !bus_req)
    else $error("bus kept after nmi or abort");
  AST_RUN_START: assert property
    (wr_mode && reg_req.wdata[15] && reg_req.wdata[9:8] == 2'h1
      && !bus_req && !evt.nmi && !evt.abort |-> ##2 bus_req)
    else $error("auto run did not start");
  // main scenarios reached
  cover property ($fell(xfer_done_n));
  cover property ($rose(irq));
  cover property (evt.nmi);
endmodule

bind dmcc_core dmcc_core_props dmcc_core_props_i (.mclk(mclk),
  .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata), .evt(evt),
  .bus_req(bus_req), .dest_addr(dest_addr),
  .dest_is_device(dest_is_device), .req_accept_oe(req_accept_oe),
  .xfer_done_n(xfer_done_n), .xfer_done_oe(xfer_done_oe), .irq(irq));

// ==== testbench/dmcc_far.sv ====
// far side: bus fabric granting units and an external request source
// assumes the core holds bus_req as a level while it wants a unit
`timescale 1ns/1ps

module dmcc_far
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic bus_req,
  input  wire logic slow,
  input  wire logic req_on,
  output logic      xfer_done,
  output logic      xfer_req_n
);
  logic [2:0] wait_q;
  // one unit per pulse, never two in a row; slow waits five cycles
  always @(posedge mclk)
  begin
    if (!resetn || !bus_req || xfer_done)
    begin
      wait_q    <= 3'h0;
      xfer_done <= 1'b0;
    end
    else if (wait_q >= (slow ? 3'h5 : 3'h0))
      xfer_done <= 1'b1;
    else
      wait_q <= wait_q + 3'h1;
  end
  // request is a held low level while service is wanted
  always @(posedge mclk)
    xfer_req_n <= !(resetn && req_on);
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the dma channel control core
// assumes the core, the far side model and the bound checker
`timescale 1ns/1ps

module testbench;
  import dmcc_pkg::*;
  logic        mclk, resetn, xfer_req_n, xfer_done, bus_req, irq;
  logic        dest_is_device, xfer_ack_n, req_accept_n, req_accept_oe;
  logic        xfer_done_n, xfer_done_oe, slow, req_on;
  logic [31:0] rdata, dest_addr, d, m;
  logic [1:0]  unit_size;
  dmcc_req_s   req;
  dmcc_evt_s   evt;
  int          errors, n_tests, pulses, dseen, aseen, lowc, p0, i;
  int          seed = 27751;

  dmcc_core dmcc_core_i (.mclk(mclk), .resetn(resetn), .reg_req(req),
    .reg_rdata(rdata), .evt(evt), .xfer_req_n(xfer_req_n),
    .xfer_done(xfer_done), .bus_req(bus_req), .dest_addr(dest_addr),
    .dest_is_device(dest_is_device), .unit_size(unit_size),
    .xfer_ack_n(xfer_ack_n), .req_accept_n(req_accept_n),
    .req_accept_oe(req_accept_oe), .xfer_done_n(xfer_done_n),
    .xfer_done_oe(xfer_done_oe), .irq(irq));
  dmcc_far dmcc_far_i (.mclk(mclk), .resetn(resetn), .bus_req(bus_req),
    .slow(slow), .req_on(req_on), .xfer_done(xfer_done),
    .xfer_req_n(xfer_req_n));

  always #2.5 mclk = ~mclk;
  // model tallies: granted units, end pulses, accepts, idle run
  always @(posedge mclk)
  begin
    if (xfer_done === 1'b1 && bus_req === 1'b1) pulses++;
    if (xfer_done_n === 1'b0 && xfer_done_oe === 1'b1) dseen++;
    if (req_accept_n === 1'b0 && req_accept_oe === 1'b1) aseen++;
    lowc = (bus_req === 1'b0) ? lowc + 1 : 0;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for a tally to reach a target
  task automatic till(ref int v, input int tgt);
    int k;
    for (k = 0; k < 500 && v < tgt; k++)
    begin
      @(posedge mclk);
      #1;
    end
    if (v < tgt)
    begin
      errors++;
      conclude();
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic ev(dmcc_evt_s e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    #1;
  endtask

  initial
  begin
    mclk = 1'b0;
    resetn = 1'b0;
    req = '0;
    evt = '0;
    slow = 1'b0;
    req_on = 1'b0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    // reset values and the unmapped slot
    for (i = 0; i < 4; i++)
    begin
      rd(i[3:0], d);
      chk("reset", d, 32'h0000_0000);
    end
    // random values, written only while idle
    for (i = 0; i < 3; i++)
    begin
      m = $random(seed);
      wr(DMCC_OFS_DEST, m);
      rd(DMCC_OFS_DEST, d);
      chk("dest", d, m & DMCC_TOP_MASK);
      chk("dest pin", dest_addr, m & DMCC_TOP_MASK);
      wr(DMCC_OFS_COUNT, m);
      rd(DMCC_OFS_COUNT, d);
      chk("count", d, m & DMCC_TOP_MASK);
    end
    $display("test registers done");
    // sizes, address modes, directions and pin enables
    for (i = 0; i < 16; i++)
    begin
      m = {i[0], i[1], 1'b0, i[2], 5'h00, i[3], i[0], 1'b0, i[1], 1'b0};
      wr(DMCC_OFS_MODE, m);
      rd(DMCC_OFS_MODE, d);
      chk("mode", d, m);
      chk("size", unit_size, i[1:0]);
      chk("devdst", dest_is_device, i[2] & ~i[3]);
      chk("oe", {xfer_done_oe, req_accept_oe}, i[1:0]);
    end
    $display("test modes done");
    // three-unit burst to the end, end pin and interrupt
    wr(DMCC_OFS_COUNT, 32'h0000_0003);
    p0 = pulses;
    i = dseen;
    wr(DMCC_OFS_MODE, 32'h0000_91A0);
    till(dseen, i + 1);
    chk("units", pulses - p0, 3);
    chk("irq", irq, 1'b1);
    rd(DMCC_OFS_COUNT, d);
    chk("left", d, 32'h0000_0000);
    rd(DMCC_OFS_MODE, m);
    chk("run flag", m & 32'h0000_8040, 32'h0000_0040);
    wr(DMCC_OFS_MODE, m & 32'h0000_FFBF);
    chk("irq clr", irq, 1'b0);
    $display("test count end done");
    // slow grants, halt after one unit, then resume to the end
    slow = 1'b1;
    wr(DMCC_OFS_COUNT, 32'h0000_0005);
    p0 = pulses;
    wr(DMCC_OFS_MODE, 32'h0000_9100);
    till(pulses, p0 + 1);
    wr(DMCC_OFS_MODE, 32'h0000_1100);
    till(lowc, 3);
    rd(DMCC_OFS_COUNT, d);
    chk("remain", d, 5 - (pulses - p0));
    slow = 1'b0;
    i = dseen;
    wr(DMCC_OFS_MODE, 32'h0000_9100);
    till(dseen, i + 1);
    chk("total", pulses - p0, 5);
    $display("test halt done");
    // zero count keeps running with no end and no interrupt
    wr(DMCC_OFS_COUNT, 32'h0000_0000);
    p0 = pulses;
    wr(DMCC_OFS_MODE, 32'h0000_80A0);
    till(pulses, p0 + 20);
    chk("no irq", irq, 1'b0);
    wr(DMCC_OFS_MODE, 32'h0000_0000);
    till(lowc, 3);
    chk("no end", dseen, i + 1);
    $display("test free run done");
    // block of four with external request, nmi part way
    slow = 1'b1;
    wr(DMCC_OFS_COUNT, 32'h0004_0002);
    p0 = pulses;
    i = aseen;
    wr(DMCC_OFS_MODE, 32'h0000_A300);
    req_on = 1'b1;
    till(pulses, p0 + 1);
    ev(4'b1000);
    till(lowc, 3);
    rd(DMCC_OFS_MODE, m);
    chk("block err", m[15:14], 2'b01);
    chk("accept", aseen > i, 1'b1);
    wr(DMCC_OFS_MODE, m & 32'h0000_BFFF);
    rd(DMCC_OFS_MODE, d);
    chk("bef clr", d[14], 1'b0);
    rd(DMCC_OFS_COUNT, d);
    chk("blk size", d[23:16], 8'h04);
    // clearing run mid-block finishes that block first, edge sense set
    wr(DMCC_OFS_COUNT, 32'h0002_0002);
    p0 = pulses;
    wr(DMCC_OFS_MODE, 32'h0000_8B00);
    till(pulses, p0 + 1);
    wr(DMCC_OFS_MODE, 32'h0000_0B00);
    till(lowc, 3);
    chk("blk units", pulses - p0, 2);
    rd(DMCC_OFS_COUNT, d);
    chk("blk left", d, 32'h0002_0001);
    rd(DMCC_OFS_MODE, m);
    chk("blk stop", m[15], 1'b0);
    req_on = 1'b0;
    slow = 1'b0;
    $display("test nmi done");
    // abort source ends a free-running burst
    p0 = pulses;
    wr(DMCC_OFS_COUNT, 32'h0000_0000);
    wr(DMCC_OFS_MODE, 32'h0000_8500);
    till(pulses, p0 + 2);
    chk("ack on", xfer_ack_n, 1'b0);
    chk("dst dev", dest_is_device, 1'b1);
    ev(4'b0100);
    till(lowc, 3);
    chk("ack off", xfer_ack_n, 1'b1);
    rd(DMCC_OFS_MODE, m);
    chk("abort", m[15], 1'b0);
    $display("test abort done");
    conclude();
  end
endmodule
